// [rtl/wdt_regs.vh]
// Watchdog block constants: register offsets, field positions, reset values,
// timing counts. Included by the watchdog design files only.
`ifndef WDT_REGS_VH
`define WDT_REGS_VH

// Avalon word addresses (byte address = 4 * index)
`define WDT_ADDR_CTRL        4'h0
`define WDT_ADDR_CAUSE       4'h1
`define WDT_ADDR_STAT        4'h2

// Control/status field positions
`define WDT_BIT_FLAG         7
`define WDT_BIT_IE           6
`define WDT_BIT_PS3          5
`define WDT_BIT_UNLOCK       4
`define WDT_BIT_RSTEN        3
// Reset cause register field
`define WDT_BIT_CAUSE        3

// Reset values
`define WDT_CTRL_RESET       8'h00
`define WDT_RSTEN_RESET      1'b0

// Unlock window in core cycles
`define WDT_UNLOCK_CYCLES    3'h4

// Reset pulse width in core cycles
`define WDT_RST_PULSE        4'h8

// Time-out lengths in oscillator ticks, one per prescaler code 0 to 13
`define WDT_LIM_C0           21'h000800
`define WDT_LIM_C1           21'h001000
`define WDT_LIM_C2           21'h002000
`define WDT_LIM_C3           21'h004000
`define WDT_LIM_C4           21'h008000
`define WDT_LIM_C5           21'h010000
`define WDT_LIM_C6           21'h020000
`define WDT_LIM_C7           21'h040000
`define WDT_LIM_C8           21'h080000
`define WDT_LIM_C9           21'h100000
`define WDT_LIM_C10          21'h000400
`define WDT_LIM_C11          21'h000200
`define WDT_LIM_C12          21'h000100
`define WDT_LIM_C13          21'h000080

// Reset vector address
`define WDT_RESET_VECTOR     16'h0000

// Prescaler codes
`define WDT_PS_RES0          4'hE
`define WDT_PS_RES1          4'hF

`endif

// [rtl/wdt_osc_counter.v]
// Watchdog time-base counter: counts enable ticks of the slow oscillator
// and flags the time-out for the selected prescaler code.
// Assumes osc_tick is a one-cycle pulse already in the core clock domain.
`timescale 1ns/10ps
`include "wdt_regs.vh"

module wdt_osc_counter (
  // Clock and reset
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        clk_en,
  // Control
  input  wire        run,
  input  wire        restart,
  input  wire [3:0]  prescale,
  input  wire        osc_tick,
  // Result
  output reg         timeout_q
);

  reg  [20:0] count_q;
  reg  [20:0] limit;

  // Time-out length per code; doubling from 2048, then the short codes
  always @* begin
    case (prescale)
      4'h0:    limit = `WDT_LIM_C0;
      4'h1:    limit = `WDT_LIM_C1;
      4'h2:    limit = `WDT_LIM_C2;
      4'h3:    limit = `WDT_LIM_C3;
      4'h4:    limit = `WDT_LIM_C4;
      4'h5:    limit = `WDT_LIM_C5;
      4'h6:    limit = `WDT_LIM_C6;
      4'h7:    limit = `WDT_LIM_C7;
      4'h8:    limit = `WDT_LIM_C8;
      4'h9:    limit = `WDT_LIM_C9;
      4'hA:    limit = `WDT_LIM_C10;
      4'hB:    limit = `WDT_LIM_C11;
      4'hC:    limit = `WDT_LIM_C12;
      4'hD:    limit = `WDT_LIM_C13;
      default: limit = `WDT_LIM_C13; // Reserved codes act like the shortest
    endcase
  end

  // Count oscillator ticks; a one-cycle time-out pulse then wrap to zero
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_q   <= 21'h000000;
      timeout_q <= 1'b0;
    end else if (clk_en) begin
      timeout_q <= 1'b0;
      if (restart || !run) begin
        count_q <= 21'h000000;
      end else if (osc_tick) begin
        if (count_q + 21'h000001 >= limit) begin
          count_q   <= 21'h000000;
          timeout_q <= 1'b1;
        end else begin
          count_q <= count_q + 21'h000001;
        end
      end
    end
  end

endmodule // wdt_osc_counter

// [rtl/wdt_control.v]
// Watchdog control and status logic with an Avalon-MM register slave.
// Assumes the 128 kHz oscillator arrives on a pin-level input, and the core
// reports vector entry, watchdog-reset instruction and global enable.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
`include "wdt_regs.vh"

module wdt_control (
  // Clock and reset
  input  wire        core_clk,
  input  wire        reset_n,
  input  wire        clk_en,
  // Avalon-MM slave
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // Core side
  input  wire        osc_128k,
  input  wire        always_on_fuse,
  input  wire        core_global_ie,
  input  wire        vector_ack,
  input  wire        restart_cmd,
  input  wire        por_event,
  output reg         irq_q,
  output reg         sys_reset_q,
  output reg  [15:0] reset_vector_q
);

  // Control/status bits
  reg        flag_q;
  reg        ie_q;
  reg        unlock_q;
  reg        rsten_q;
  reg  [3:0] ps_q;
  reg  [2:0] unlock_cnt_q;
  reg        cause_q;
  reg        fuse_q;
  reg  [3:0] rst_cnt_q;
  reg        ack_q;
  // Oscillator synchroniser and edge detect
  reg  [2:0] osc_sync_q;
  reg        osc_state_q;
  wire       osc_tick;
  wire       timeout;

  // Effective mode bits, fuse overrides software
  wire       eff_rsten = fuse_q | rsten_q | cause_q;
  wire       eff_ie    = ie_q & ~fuse_q;
  wire       running   = eff_rsten | eff_ie;
  wire [7:0] ctrl_rd   = {flag_q, eff_ie, ps_q[3], unlock_q, eff_rsten,
                          ps_q[2:0]};

  // Bus access decode; one wait cycle then answer
  wire       acc     = (avs_read | avs_write) & avs_waitrequest;
  wire       wr_ctrl = acc & avs_write & avs_byteenable[0]
                       & (avs_address == `WDT_ADDR_CTRL);
  wire       wr_cause = acc & avs_write & avs_byteenable[0]
                        & (avs_address == `WDT_ADDR_CAUSE);
  wire [7:0] wd      = avs_writedata[7:0];

  // Three-stage sync; a change counts when stages two and three agree
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      osc_sync_q  <= 3'h0;
      osc_state_q <= 1'b0;
    end else if (clk_en) begin
      osc_sync_q <= {osc_sync_q[1:0], osc_128k};
      if (osc_sync_q[1] == osc_sync_q[2]) begin
        osc_state_q <= osc_sync_q[2];
      end
    end
  end

  // One tick per rising oscillator edge
  assign osc_tick = (osc_sync_q[1] == osc_sync_q[2]) & osc_sync_q[2]
                    & ~osc_state_q;

  // Time base
  wdt_osc_counter u_counter (
    .core_clk  (core_clk),
    .reset_n   (reset_n),
    .clk_en    (clk_en),
    .run       (running),
    .restart   (restart_cmd),
    .prescale  (ps_q),
    .osc_tick  (osc_tick),
    .timeout_q (timeout)
  );

  // Fuse is a strap, caught by clocked logic after reset release
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      fuse_q <= 1'b0;
    end else if (clk_en) begin
      fuse_q <= always_on_fuse;
    end
  end

  // Vector entry edge, so a held acknowledge clears only once
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_q <= 1'b0;
    end else if (clk_en) begin
      ack_q <= vector_ack;
    end
  end

  wire ack_pulse = vector_ack & ~ack_q;

  // Reset decision for this time-out
  wire do_reset = timeout & eff_rsten & (~eff_ie | flag_q);

  // Control register update
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q       <= 1'b0;
      ie_q         <= 1'b0;
      unlock_q     <= 1'b0;
      rsten_q      <= `WDT_RSTEN_RESET;
      ps_q         <= 4'h0;
      unlock_cnt_q <= 3'h0;
    end else if (clk_en) begin
      // Unlock window countdown
      if (unlock_cnt_q != 3'h0) begin
        unlock_cnt_q <= unlock_cnt_q - 3'h1;
        if (unlock_cnt_q == 3'h1) begin
          unlock_q <= 1'b0;
        end
      end
      if (wr_ctrl) begin
        ie_q <= wd[`WDT_BIT_IE];
        // Setting rsten is always allowed; clearing needs the unlock
        if (wd[`WDT_BIT_RSTEN] || unlock_q) begin
          rsten_q <= wd[`WDT_BIT_RSTEN];
        end
        if (unlock_q) begin
          ps_q <= {wd[`WDT_BIT_PS3], wd[2:0]};
        end
        // Unlock opens only when written together with rsten
        if (wd[`WDT_BIT_UNLOCK] && wd[`WDT_BIT_RSTEN]) begin
          unlock_q     <= 1'b1;
          unlock_cnt_q <= `WDT_UNLOCK_CYCLES;
        end else begin
          unlock_q     <= 1'b0;
          unlock_cnt_q <= 3'h0;
        end
      end
      // Vector entry in combined mode drops the enable
      if (ack_pulse && flag_q && eff_rsten) begin
        ie_q <= 1'b0;
      end
      // Flag: set wins over write-one clear and vector clear
      if (timeout && eff_ie && !do_reset) begin
        flag_q <= 1'b1;
      end else if (ack_pulse) begin
        flag_q <= 1'b0;
      end else if (wr_ctrl && wd[`WDT_BIT_FLAG]) begin
        flag_q <= 1'b0;
      end
    end
  end

  // Reset cause flag: set by watchdog reset, cleared by software or power-on
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cause_q <= 1'b0;
    end else if (clk_en) begin
      if (do_reset) begin
        cause_q <= 1'b1;
      end else if (por_event) begin
        cause_q <= 1'b0;
      end else if (wr_cause && !wd[`WDT_BIT_CAUSE]) begin
        cause_q <= 1'b0;
      end
    end
  end

  // System reset pulse to the core, with the vector it must take
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_cnt_q      <= 4'h0;
      sys_reset_q    <= 1'b0;
      reset_vector_q <= `WDT_RESET_VECTOR;
    end else if (clk_en) begin
      if (do_reset) begin
        rst_cnt_q      <= `WDT_RST_PULSE;
        sys_reset_q    <= 1'b1;
        reset_vector_q <= `WDT_RESET_VECTOR;
      end else if (rst_cnt_q != 4'h0) begin
        rst_cnt_q   <= rst_cnt_q - 4'h1;
        sys_reset_q <= (rst_cnt_q != 4'h1);
      end
    end
  end

  // Interrupt request; core global enable gates it
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else if (clk_en) begin
      irq_q <= flag_q & eff_ie & core_global_ie;
    end
  end

  // Avalon slave: waitrequest high until one cycle after the request
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end else if (clk_en) begin
      if (acc) begin
        avs_waitrequest <= 1'b0;
        case (avs_address)
          `WDT_ADDR_CTRL:  avs_readdata <= {24'h000000, ctrl_rd};
          `WDT_ADDR_CAUSE: avs_readdata <= {28'h0000000, cause_q, 3'h0};
          `WDT_ADDR_STAT:  avs_readdata <= {28'h0000000, fuse_q, running,
                                            eff_ie, eff_rsten};
          default:         avs_readdata <= 32'h00000000;
        endcase
      end else begin
        avs_waitrequest <= 1'b1;
      end
    end
  end

endmodule // wdt_control

// [verif/wdt_control_sva.sv]
// Checker for the watchdog control block, bound to its ports.
// Assumes a single core clock domain with clk_en held high.
`timescale 1ns/10ps
module wdt_control_chk (
  // Clock and reset
  input wire        core_clk,
  input wire        reset_n,
  // Register bus
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  // Core side
  input wire        always_on_fuse,
  input wire        core_global_ie,
  input wire        irq_q,
  input wire        sys_reset_q,
  input wire [15:0] reset_vector_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Bus answer timing: one wait cycle, low for one cycle
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("bus answer late");
  wait_stand_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  // Unmapped places and upper lanes read zero
  hole_zero_a: assert property (avs_read && avs_waitrequest &&
    avs_address > 4'h2 |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  upper_zero_a: assert property (!avs_waitrequest
    |-> avs_readdata[31:8] == 24'h0) else $error("upper lanes not zero");
  // Request only with the core global enable, and never once the fuse has been held for three cycles
  irq_gate_a: assert property (
    irq_q |-> $past(core_global_ie)) else $error("irq without global ie");
  irq_mask_a: assert property (
    !core_global_ie |=> !irq_q) else $error("irq not masked");
  fuse_mask_a: assert property (
    always_on_fuse [*3] |-> !irq_q) else $error("irq with fuse");
  // Reset pulse length and vector
  rst_pulse_a: assert property (
    $rose(sys_reset_q) |-> sys_reset_q [*8] ##1 !sys_reset_q)
    else $error("reset pulse length wrong");
  reset_vec_a: assert property (
    sys_reset_q |-> reset_vector_q == 16'h0000) else $error("bad vector");
endmodule // wdt_control_chk

bind wdt_control wdt_control_chk u_chk (.core_clk, .reset_n,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest,
  .always_on_fuse, .core_global_ie, .irq_q, .sys_reset_q, .reset_vector_q);

// [verif/wdt_core_model.sv]
// Model of the core side: slow oscillator and watchdog vector entry.
// Assumes the bench sets how many cycles the core takes to take a request.
`timescale 1ns/10ps
module wdt_core_model (
  // Clock
  input  wire       core_clk,
  // Watchdog side
  input  wire       irq_q,
  input  wire [3:0] ack_wait,
  output logic      osc_128k,
  output logic      vector_ack
);
  // Free-running oscillator, scaled to 10 core cycles so runs stay short
  initial begin
    osc_128k = 1'b0;
    forever begin
      repeat (5) @(posedge core_clk);
      osc_128k <= ~osc_128k;
    end
  end
  // Vector entry strobe some cycles after a taken request
  initial begin
    vector_ack = 1'b0;
    forever begin
      @(posedge core_clk);
      if (irq_q === 1'b1) begin
        repeat (ack_wait) @(posedge core_clk);
        vector_ack <= 1'b1;
        @(posedge core_clk);
        vector_ack <= 1'b0;
        repeat (4) @(posedge core_clk); // Let the request drop first
      end
    end
  end
endmodule // wdt_core_model

// [verif/tb_wdt_control.sv]
// Self-checking bench for the watchdog control block.
// Assumes the core model drives oscillator and vector entry.
`timescale 1ns/10ps
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb_wdt_control;
  logic        core_clk, reset_n, avs_read, avs_write, fuse, gie, kick_req;
  logic        waitreq, irq, sres, ack, osc;
  logic [3:0]  avs_address, ack_wait;
  logic [31:0] avs_writedata, rdata, q;
  logic [15:0] vec;
  int          errors, n_checks, t0;
  // Rows: write nibble, address, write data, expected read data
  logic [23:0] rows [15] = '{24'h00_00_00, 24'h10_40_00,
    24'h00_00_40, 24'h10_4D_00, 24'h00_00_48,
    24'h10_18_00, 24'h10_0D_00, 24'h00_00_0D,
    24'h10_00_00, 24'h00_00_0D, 24'h13_FF_00,
    24'h03_00_00, 24'h10_18_00, 24'h10_00_00, 24'h00_00_00};

  wdt_control DUT (.core_clk(core_clk), .reset_n(reset_n), .clk_en(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(rdata), .avs_waitrequest(waitreq), .osc_128k(osc),
    .always_on_fuse(fuse), .core_global_ie(gie), .vector_ack(ack),
    .restart_cmd(kick_req), .por_event(1'b0), .irq_q(irq),
    .sys_reset_q(sres),
    .reset_vector_q(vec));
  wdt_core_model u_core (.core_clk(core_clk), .irq_q(irq),
    .ack_wait(ack_wait), .osc_128k(osc), .vector_ack(ack));

  // Clock, 20 ns period
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Watchdog against hangs
  initial begin
    repeat (30000) @(posedge core_clk);
    errors++;
    end_of_test();
  end

  // One transfer, held until waitrequest is seen low; the watchdog bounds it
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [7:0] d, output logic [31:0] r);
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= {24'h0, d};
    do begin
      @(posedge core_clk);
    end while (waitreq !== 1'b0);
    r = rdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  // Poll the control register until the flag shows
  task automatic poll_flag();
    q = '0;
    for (int n = 0; n < 900 && q[7] !== 1'b1; n++) bus(0, 0, 0, q);
  endtask
  // Wait for a core-side strobe under a bound
  task automatic wait_hi(ref logic s);
    for (int n = 0; n < 3000 && s !== 1'b1; n++) @(posedge core_clk);
  endtask
  task automatic unlock(input logic [7:0] d);
    bus(1, 0, 8'h18, q);
    bus(1, 0, d, q);
  endtask
  task automatic kick();
    @(posedge core_clk) kick_req <= 1'b1;
    @(posedge core_clk) kick_req <= 1'b0;
    t0 = $time / 20;
  endtask
  task automatic end_of_test();
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    {avs_read, avs_write, fuse, gie, kick_req} = '0;
    avs_address = '0;
    avs_writedata = '0;
    ack_wait = 4'h1;
    reset_n = 1'b0;
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      bus(rows[i][20], rows[i][19:16], rows[i][15:8], q);
      if (!rows[i][20]) `CHK("row", rows[i][7:0], q[7:0])
    end
    // Interrupt mode, 128-tick code (1280 core cycles), core interrupts masked
    unlock(8'h65);
    kick();
    poll_flag();
    `CHK("flag", 8'hE5, q[7:0])
    `CHK("period", 1'b1, ($time/20 - t0 inside {[1260:1310]}))
    `CHK("masked", 1'b0, irq)
    bus(1, 0, 8'h65, q);
    bus(0, 0, 0, q);
    `CHK("w0", 8'hE5, q[7:0])
    bus(1, 0, 8'hE5, q);
    bus(0, 0, 0, q);
    `CHK("w1", 8'h65, q[7:0])
    // Combined mode, core takes the vector slowly
    ack_wait <= 4'h9;
    gie <= 1'b1;
    bus(1, 0, 8'h6D, q);
    kick();
    wait_hi(ack);
    `CHK("irq", 1'b1, irq)
    repeat (4) @(posedge core_clk);
    bus(0, 0, 0, q);
    `CHK("vector", 8'h2D, q[7:0])
    wait_hi(sres);
    `CHK("reset", 1'b1, sres)
    `CHK("vec", 16'h0000, vec)
    bus(0, 1, 0, q);
    `CHK("cause", 8'h08, q[7:0] & 8'h08)
    // Unserviced request leads to reset at the next time-out
    gie <= 1'b0;
    unlock(8'h6D);
    kick();
    poll_flag();
    `CHK("no early rst", 1'b0, sres)
    wait_hi(sres);
    `CHK("late rst", 1'b1, sres)
    unlock(8'h00);
    bus(0, 0, 0, q);
    `CHK("held", 8'h08, q[7:0] & 8'h08)
    bus(1, 1, 8'h00, q);
    unlock(8'h00);
    bus(0, 0, 0, q);
    `CHK("freed", 8'h00, q[7:0] & 8'h08)
    // Always-on fuse forces reset mode, even with flag and both enables set
    fuse <= 1'b1;
    gie  <= 1'b1;
    repeat (3) @(posedge core_clk);
    bus(1, 0, 8'h40, q);
    bus(0, 0, 0, q);
    `CHK("fuse", 8'h08, q[7:0] & 8'h48)
    `CHK("fuse irq", 1'b0, irq)
    bus(0, 2, 0, q);
    `CHK("status", 8'h0D, q[7:0])
    // Mid-run reset: bus idle, outputs low, flag and enable gone
    reset_n <= 1'b0;
    @(posedge core_clk);
    `CHK("rst wait", 1'b1, waitreq)
    `CHK("rst outs", 1'b0, irq | sres)
    reset_n <= 1'b1;
    bus(0, 0, 0, q);
    `CHK("rst ctrl", 8'h08, q[7:0])
    end_of_test();
  end
endmodule // tb_wdt_control
